// ### design/hc_dma_pkg.sv
package hc_dma_pkg;
    // =====================================================
    // Command codes
    localparam logic [7:0] CMD_SETUP_RD = 8'h21;
    localparam logic [7:0] CMD_SETUP_WR = 8'hA1;
    localparam logic [7:0] CMD_COUNT_RD = 8'h22;
    localparam logic [7:0] CMD_COUNT_WR = 8'hA2;
    localparam logic [7:0] CMD_IRQ_RD = 8'h24;
    localparam logic [7:0] CMD_IRQ_WR = 8'hA4;
    // =====================================================
    // Field positions
    localparam int DIR_BIT = 0;
    localparam int LIST_BIT = 1;
    localparam int CNT_USE_BIT = 2;
    localparam int GO_BIT = 4;
    localparam int BURST_LO = 5;
    localparam int DONE_BIT = 2;
    localparam logic [15:0] SETUP_MASK = 16'h0077;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    // =====================================================
    // Burst codes and limits
    localparam logic [1:0] BURST_1 = 2'h0;
    localparam logic [1:0] BURST_4 = 2'h1;
    localparam logic [1:0] BURST_8 = 2'h2;
    localparam logic [15:0] ACK_LIMIT = 16'h1000;
    localparam logic [15:0] ISO_LIMIT = 16'h0800;
    localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
    // =====================================================
    // Host register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_RESULT = 4'h3;
endpackage

// ### design/hc_dma_if.sv
// =====================================================
// Link between the host controller end and the CPU/DMA end.
interface hc_dma_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic [15:0] cmd_rdata;
    logic xfer_req;
    logic dack;
    logic xfer_end;
    modport device (input cmd_valid, input cmd_code, input cmd_wdata, output cmd_rdata,
                    output xfer_req, input dack, input xfer_end);
    modport cpu (output cmd_valid, output cmd_code, output cmd_wdata, input cmd_rdata,
                 input xfer_req, output dack, output xfer_end);
endinterface

// ### design/hc_burst_counter.sv
// =====================================================
// Counts data cycles of one burst and reports its end.
module hc_burst_counter (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic step_in,
    input wire logic [1:0] code_in,
    output logic busy_out,
    output logic last_out
);
    logic [3:0] left_q;
    logic [3:0] len;

    // Burst length from code.
    assign len = (code_in == hc_dma_pkg::BURST_8) ? 4'h8 :
                 (code_in == hc_dma_pkg::BURST_4) ? 4'h4 : 4'h1;
    assign busy_out = (left_q != 4'h0);
    assign last_out = busy_out && step_in && (left_q == 4'h1);

    // Load on start, count down per data cycle.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            left_q <= 4'h0;
        end else if (start_in) begin
            left_q <= len;
        end else if (busy_out && step_in) begin
            left_q <= left_q - 4'h1;
        end
    end
endmodule // hc_burst_counter

// ### design/hc_dma_device.sv
// =====================================================
// Host controller side: setup, byte count, request and done flag.
//
// Chosen here: the plain strobed port.
module hc_dma_device (
    input wire logic mclk_in,
    input wire logic rstn_in,
    hc_dma_if.device link,
    input wire logic abort_in,
    output logic buf_sel_out,
    output logic dir_out,
    output logic ram_strobe_out,
    output logic [15:0] buffer_fill_status_out
);
    logic [15:0] setup_q;
    logic [15:0] count_q;
    logic [15:0] dma_cnt_q;
    logic done_q;
    logic [15:0] fill_q;
    logic [15:0] rdata_q;
    logic wr_setup, wr_count, wr_irq, step, int_end, any_end, go, cnt_use;
    logic start, burst_busy, burst_last, can_req, flush;

    // =====================================================
    // Command decode.
    assign wr_setup = link.cmd_valid && link.cmd_code == hc_dma_pkg::CMD_SETUP_WR;
    assign wr_count = link.cmd_valid && link.cmd_code == hc_dma_pkg::CMD_COUNT_WR;
    assign wr_irq = link.cmd_valid && link.cmd_code == hc_dma_pkg::CMD_IRQ_WR;
    assign go = setup_q[hc_dma_pkg::GO_BIT];
    assign cnt_use = setup_q[hc_dma_pkg::CNT_USE_BIT];
    assign buf_sel_out = setup_q[hc_dma_pkg::LIST_BIT];
    assign dir_out = setup_q[hc_dma_pkg::DIR_BIT];

    // Request logic: counted mode needs a nonzero count.
    assign can_req = go && (!cnt_use || dma_cnt_q != 16'h0000);
    assign start = can_req && !burst_busy;
    // The request drops with go; a burst cut short is flushed so that none resumes later.
    assign flush = burst_busy && !go;
    assign link.xfer_req = burst_busy && go;
    assign step = link.xfer_req && link.dack;
    assign ram_strobe_out = step;
    assign int_end = cnt_use && step && dma_cnt_q <= hc_dma_pkg::BYTES_PER_WORD;
    assign any_end = int_end || link.xfer_end;
    assign buffer_fill_status_out = fill_q;

    hc_burst_counter u_hc_burst_counter (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .start_in(start),
        .step_in(step || flush),
        .code_in(setup_q[hc_dma_pkg::BURST_LO +: 2]),
        .busy_out(burst_busy),
        .last_out(burst_last)
    );

    // =====================================================
    // Setup register: go self-clears at end, software write aborts.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            setup_q <= hc_dma_pkg::RESET_VAL;
        end else if (wr_setup) begin
            setup_q <= link.cmd_wdata & hc_dma_pkg::SETUP_MASK;
        end else if ((any_end && go) || abort_in) begin
            setup_q[hc_dma_pkg::GO_BIT] <= 1'b0;
        end
    end

    // Byte count register and internal DMA counter.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_q <= hc_dma_pkg::RESET_VAL;
            dma_cnt_q <= hc_dma_pkg::RESET_VAL;
        end else begin
            if (wr_count) begin
                count_q <= link.cmd_wdata;
            end
            if (wr_count && cnt_use) begin
                dma_cnt_q <= link.cmd_wdata;
            end else if (wr_setup && link.cmd_wdata[hc_dma_pkg::CNT_USE_BIT]) begin
                dma_cnt_q <= count_q;
            end else if (step && cnt_use) begin
                dma_cnt_q <= (dma_cnt_q > hc_dma_pkg::BYTES_PER_WORD) ?
                             dma_cnt_q - hc_dma_pkg::BYTES_PER_WORD : 16'h0000;
            end
        end
    end

    // Done flag: set wins over a write-one clear.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            done_q <= 1'b0;
            fill_q <= hc_dma_pkg::RESET_VAL;
        end else begin
            if (any_end) begin
                done_q <= 1'b1;
            end else if (wr_irq && link.cmd_wdata[hc_dma_pkg::DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (int_end) begin
                fill_q[buf_sel_out] <= !dir_out;
            end
        end
    end

    // Read data one cycle after the read command.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 16'h0000;
        end else if (link.cmd_valid) begin
            case (link.cmd_code)
                hc_dma_pkg::CMD_SETUP_RD: rdata_q <= setup_q;
                hc_dma_pkg::CMD_COUNT_RD: rdata_q <= count_q;
                hc_dma_pkg::CMD_IRQ_RD: rdata_q <= {13'h0000, done_q, 2'h0};
                default: rdata_q <= 16'h0000;
            endcase
        end
    end
    assign link.cmd_rdata = rdata_q;
endmodule // hc_dma_device

// ### design/hc_dma_cpu.sv
// =====================================================
// CPU side: register port to commands, DMA acknowledge and end.
module hc_dma_cpu (
    input wire logic mclk_in,
    input wire logic rstn_in,
    hc_dma_if.cpu link,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out
);
    logic [7:0] code_q;
    logic ack_en_q, end_q, valid_q, rd_pend_q;
    logic [15:0] wdata_q, result_q, words_q;
    logic [15:0] rdata_q;
    logic ext_end;

    // Software issues command by writing CTRL with bit 10 set; bit 8 acks, bit 9 ends.
    assign ext_end = wr_in && addr_in == hc_dma_pkg::REG_CTRL && wdata_in[9];
    assign link.cmd_valid = valid_q;
    assign link.cmd_code = code_q;
    assign link.cmd_wdata = wdata_q;
    assign link.dack = link.xfer_req && ack_en_q;
    assign link.xfer_end = end_q;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code_q <= 8'h00;
            wdata_q <= 16'h0000;
            valid_q <= 1'b0;
            ack_en_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            valid_q <= wr_in && addr_in == hc_dma_pkg::REG_CTRL && wdata_in[10];
            end_q <= ext_end;
            if (wr_in && addr_in == hc_dma_pkg::REG_CTRL) begin
                code_q <= wdata_in[7:0];
                ack_en_q <= wdata_in[8];
            end
            if (wr_in && addr_in == hc_dma_pkg::REG_DATA) begin
                wdata_q <= wdata_in;
            end
        end
    end

    // Capture device answer and count acknowledged words.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_pend_q <= 1'b0;
            result_q <= 16'h0000;
            words_q <= 16'h0000;
            rdata_q <= 16'h0000;
        end else begin
            rd_pend_q <= valid_q;
            if (rd_pend_q) begin
                result_q <= link.cmd_rdata;
            end
            if (link.dack) begin
                words_q <= words_q + 16'h0001;
            end
            if (rd_in) begin
                case (addr_in)
                    hc_dma_pkg::REG_CTRL: rdata_q <= {5'h00, end_q, ack_en_q, valid_q, code_q};
                    hc_dma_pkg::REG_DATA: rdata_q <= wdata_q;
                    hc_dma_pkg::REG_STAT: rdata_q <= {15'h0000, link.xfer_req};
                    hc_dma_pkg::REG_RESULT: rdata_q <= result_q;
                    default: rdata_q <= words_q;
                endcase
            end
        end
    end
    assign rdata_out = rdata_q;
endmodule // hc_dma_cpu

// ### test/hc_dma_sva.sv
// ========================================
// Watches the command link between the two ends.
module hc_dma_sva (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic xfer_req,
    input wire logic dack,
    input wire logic xfer_end
);
    logic [15:0] setup_q, cnt_q, words_q;
    logic rd24_q, done_q;
    // Decoded writes seen on the link.
    wire w_setup = cmd_valid && cmd_code == hc_dma_pkg::CMD_SETUP_WR;
    wire w_count = cmd_valid && cmd_code == hc_dma_pkg::CMD_COUNT_WR;
    wire w_clear = cmd_valid && cmd_code == hc_dma_pkg::CMD_IRQ_WR && cmd_wdata[2];
    // Shadow of what software programmed and of the done flag last read.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            setup_q <= 16'h0000;
            cnt_q <= 16'h0000;
            words_q <= 16'h0000;
            rd24_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            rd24_q <= cmd_valid && cmd_code == hc_dma_pkg::CMD_IRQ_RD;
            if (w_setup) setup_q <= cmd_wdata;
            if (w_count) cnt_q <= cmd_wdata;
            words_q <= w_setup ? 16'h0000 : words_q + {15'h0000, dack};
            done_q <= rd24_q ? cmd_rdata[2] : (w_clear ? 1'b0 : done_q);
        end
    end
    // ========================================
    // Checks on the link.
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    property p_setup_rsvd; cmd_valid && cmd_code == hc_dma_pkg::CMD_SETUP_RD |=> (cmd_rdata & 16'hFF88) == 16'h0000; endproperty
    a_setup_rsvd: assert property (p_setup_rsvd) else $error("setup reserved bits not zero");
    property p_count_back; cmd_valid && cmd_code == hc_dma_pkg::CMD_COUNT_RD && !setup_q[2] |=> cmd_rdata == cnt_q; endproperty
    a_count_back: assert property (p_count_back) else $error("byte count read back wrong");
    property p_go_first; $rose(xfer_req) |-> setup_q[4]; endproperty
    a_go_first: assert property (p_go_first) else $error("request without go");
    property p_nonzero; $rose(xfer_req) && setup_q[2] |-> cnt_q != 16'h0000; endproperty
    a_nonzero: assert property (p_nonzero) else $error("request with zero count");
    property p_burst4; $rose(dack) && setup_q[6:5] == hc_dma_pkg::BURST_4 && cnt_q >= 16'h0008 |-> dack[*4]; endproperty
    a_burst4: assert property (p_burst4) else $error("four cycle burst cut short");
    property p_burst8; $rose(dack) && setup_q[6:5] == hc_dma_pkg::BURST_8 && cnt_q >= 16'h0010 |-> dack[*8]; endproperty
    a_burst8: assert property (p_burst8) else $error("eight cycle burst cut short");
    property p_words; dack && setup_q[2] |-> words_q < {1'b0, cnt_q[15:1]}; endproperty
    a_words: assert property (p_words) else $error("word beyond byte count");
    property p_sticky; cmd_valid && cmd_code == hc_dma_pkg::CMD_IRQ_RD && done_q |=> cmd_rdata[2]; endproperty
    a_sticky: assert property (p_sticky) else $error("done flag lost without clear");
endmodule // hc_dma_sva

// ### test/test_hc_buffer_dma_setup.sv
// ========================================
// Drives the register port and checks the transfers that follow.
module test_hc_buffer_dma_setup;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0, rstn_in = 1'b0, abort_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ack_en = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, q, rdata_out, fill;
    logic buf_sel, dir, strobe;
    int failures = 0, compares = 0, strobes = 0;
    hc_dma_if link();
    hc_dma_device u_hc_dma_device (.mclk_in(mclk_in), .rstn_in(rstn_in), .link(link), .abort_in(abort_in),
        .buf_sel_out(buf_sel), .dir_out(dir), .ram_strobe_out(strobe), .buffer_fill_status_out(fill));
    hc_dma_cpu u_hc_dma_cpu (.mclk_in(mclk_in), .rstn_in(rstn_in), .link(link), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
    hc_dma_sva u_hc_dma_sva (.mclk_in(mclk_in), .rstn_in(rstn_in), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cmd_wdata(link.cmd_wdata), .cmd_rdata(link.cmd_rdata),
        .xfer_req(link.xfer_req), .dack(link.dack), .xfer_end(link.xfer_end));
    // Clock and a count of buffer strobes.
    always #20 mclk_in = !mclk_in;
    always @(posedge mclk_in) if (strobe === 1'b1) strobes++;
    // Compares one value and reports a mismatch.
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One write or read cycle on the register port; read data land in q.
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        @(negedge mclk_in);
        q = rdata_out;
    endtask
    // Sends one command to the device end, then waits three cycles for its answer.
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        bus(1'b1, hc_dma_pkg::REG_DATA, d);
        bus(1'b1, hc_dma_pkg::REG_CTRL, {5'h00, 1'b1, 1'b0, ack_en, c});
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic get(input logic [7:0] c);
        cmd(c, 16'h0000);
        bus(1'b0, hc_dma_pkg::REG_RESULT, 16'h0000);
    endtask
    task automatic stat(input logic [15:0] e);
        bus(1'b0, hc_dma_pkg::REG_STAT, 16'h0000);
        chk("request", q & 16'h0001, e);
    endtask
    // Polls the go bit until the device drops it, within a bound.
    task automatic wait_idle;
        for (int i = 0; i < 40; i++) begin
            get(hc_dma_pkg::CMD_SETUP_RD);
            if (q[4] === 1'b0) return;
        end
        failures++;
        wrap_up();
    endtask
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        get(hc_dma_pkg::CMD_SETUP_RD);
        chk("setup", q, 16'h0000);
        get(hc_dma_pkg::CMD_COUNT_RD);
        chk("count", q, 16'h0000);
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'hFF9F);
        stat(16'h0000);
        chk("sel_dir", {14'h0000, buf_sel, dir}, 16'h0003);
        get(hc_dma_pkg::CMD_SETUP_RD);
        chk("setup", q, 16'h0017);
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'h0000);
        chk("sel_dir", {14'h0000, buf_sel, dir}, 16'h0000);
        cmd(hc_dma_pkg::CMD_COUNT_WR, 16'h1234);
        get(hc_dma_pkg::CMD_COUNT_RD);
        chk("count", q, 16'h1234);
        $display("test registers done");
        ack_en = 1'b1;
        for (int b = 0; b < 3; b++) begin
            cmd(hc_dma_pkg::CMD_COUNT_WR, 16'h0010);
            strobes = 0;
            cmd(hc_dma_pkg::CMD_SETUP_WR, {9'h000, b[1:0], 3'h5, b[1], b[0]});
            wait_idle();
            chk("words", strobes[15:0], 16'h0008);
            bus(1'b0, 4'h4, 16'h0000);
            chk("acks", q, 16'(8 * (b + 1)));
            chk("fill", {15'h0000, fill[b[1]]}, {15'h0000, !b[0]});
            get(hc_dma_pkg::CMD_IRQ_RD);
            chk("done", q & 16'h0004, 16'h0004);
            get(hc_dma_pkg::CMD_IRQ_RD);
            chk("done", q & 16'h0004, 16'h0004);
            cmd(hc_dma_pkg::CMD_IRQ_WR, 16'h0004);
            get(hc_dma_pkg::CMD_IRQ_RD);
            chk("done", q & 16'h0004, 16'h0000);
        end
        $display("test counted done");
        ack_en = 1'b0;
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'h0010);
        stat(16'h0001);
        bus(1'b1, hc_dma_pkg::REG_CTRL, 16'h0200);
        get(hc_dma_pkg::CMD_IRQ_RD);
        chk("done", q & 16'h0004, 16'h0004);
        wait_idle();
        cmd(hc_dma_pkg::CMD_COUNT_WR, 16'h0010);
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'h0014);
        stat(16'h0001);
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'h0000);
        stat(16'h0000);
        cmd(hc_dma_pkg::CMD_SETUP_WR, 16'h0014);
        @(posedge mclk_in);
        abort_in <= 1'b1;
        @(posedge mclk_in);
        abort_in <= 1'b0;
        get(hc_dma_pkg::CMD_SETUP_RD);
        chk("go", q & 16'h0010, 16'h0000);
        $display("test end and abort done");
        wrap_up();
    end
endmodule // test_hc_buffer_dma_setup
